/* File: logic/swtcm_clkmon.v */
`timescale 1ns/10ps
`default_nettype none
`include "swtcm_consts.vh"

module swtcm_clkmon #(
  parameter integer LIMIT = `SWTCM_CM_LIMIT_CYC,
  parameter integer CW = 16
) (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire mon_clk,
  output reg err_r
);

  reg prev_r;
  reg [CW-1:0] cnt_r;
  wire edge_seen;

  assign edge_seen = prev_r ^ mon_clk;

  // Any edge of the watched clock within LIMIT proves it fast enough
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
      cnt_r <= {CW{1'b0}};
      err_r <= 1'b0;
    end else begin
      prev_r <= mon_clk;
      if (edge_seen) begin
        cnt_r <= {CW{1'b0}};
        err_r <= 1'b0;
      end else if (cnt_r == LIMIT[CW-1:0] - 1'b1) begin
        err_r <= enable;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
      if (!enable) begin
        err_r <= 1'b0;
      end
    end
  end

endmodule // swtcm_clkmon

`default_nettype wire

/* File: logic/swtcm_consts.vh */
`ifndef SWTCM_CONSTS_VH
`define SWTCM_CONSTS_VH

// Register byte addresses
`define SWTCM_ADDR_SVC 8'h00
`define SWTCM_ADDR_OPT 8'h04
`define SWTCM_ADDR_STAT 8'h08
`define SWTCM_ADDR_CNT 8'h0c

// Service register fields
`define SWTCM_SEL_HI 7
`define SWTCM_SEL_LO 6
`define SWTCM_KEY_HI 5
`define SWTCM_KEY_LO 1
`define SWTCM_CM_BIT 0
`define SWTCM_KEY_VALUE 5'h0c
`define SWTCM_SEL_RESET 2'h3
`define SWTCM_CM_RESET 1'h1

// Option register
`define SWTCM_OPT_WD_DIS_BIT 2
`define SWTCM_OPT_RESET 8'h00

// Status register bits
`define SWTCM_ST_FAULT 0
`define SWTCM_ST_CMERR 1
`define SWTCM_ST_CONFIG 2
`define SWTCM_ST_TIMEOUT 3
`define SWTCM_ST_EARLY 4
`define SWTCM_ST_MISMATCH 5
`define SWTCM_ST_CLOCK 6

// Timing
`define SWTCM_CLK_NS 100
`define SWTCM_TC_NS 1000
`define SWTCM_TC_DIV (`SWTCM_TC_NS / `SWTCM_CLK_NS)
`define SWTCM_LOWER_TC 256
`define SWTCM_WIN_BASE_TC 17'h02000
`define SWTCM_HOLD_TC 16
`define SWTCM_CM_LIMIT_NS 1000000
`define SWTCM_CM_LIMIT_CYC (`SWTCM_CM_LIMIT_NS / `SWTCM_CLK_NS)

`endif

/* File: logic/swtcm_top.v */
// Function
// - Service byte: window, key, monitor select
// - Key field must equal 01100
// - Lower bound 256 cycles after service
// - Window select picks 8k to 64k
// - Monitor select bit disables or enables
// - Option bit 2 low enables pin
// - Reset idles both; then armed, maximal
// - Slow or dead clock after reset errors
// - First keyed write loads fields once
// - Later writes compare bits 7 to 0
// - Later service before lower bound is error
// - First configuring write counts as service
// - Match restarts window; mismatch faults
// - Active low pin, pull-up when idle
// - Hold pin 16-32 cycles after low
// - Window restarts when pin goes high
// - Service during fault is ignored
// - Pin low at power-up times out
// - Clock error holds pin until recovery
// - Accept 10 kHz, reject below 10 Hz
// - Key reads back as zeros
`timescale 1ns/10ps
`default_nettype none
`include "swtcm_consts.vh"

module swtcm_top #(
  parameter integer TC_DIV = `SWTCM_TC_DIV,
  parameter integer LOWER_TC = `SWTCM_LOWER_TC,
  parameter integer HOLD_TC = `SWTCM_HOLD_TC,
  parameter integer CM_LIMIT = `SWTCM_CM_LIMIT_CYC
) (
  input wire CLOCK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire CLOCK_INPUT_PIN,
  input wire FAULT_PIN_IN,
  output reg FAULT_PIN_OUT,
  output reg FAULT_PIN_OE,
  output reg FAULT_PIN_PULLUP
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_DRIVE = 4'h2;
  localparam [3:0] ST_HOLD = 4'h4;
  localparam [3:0] ST_REL = 4'h8;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [3:0] tc_cnt_r;
  reg tick_r;
  reg [16:0] win_cnt_r;
  reg [16:0] win_cnt_nxt;
  reg [5:0] hold_cnt_r;
  reg [5:0] hold_cnt_nxt;
  reg [1:0] sel_r;
  reg cm_en_r;
  reg config_r;
  reg [7:0] opt_r;
  reg [3:0] cause_r;
  reg [3:0] cause_set;
  reg [31:0] rdata_mux;
  reg addr_ok;
  reg configure_now;

  wire wd_en;
  wire cm_err;
  wire access;
  wire wr_svc;
  wire wr_opt;
  wire wr_stat;
  wire [16:0] upper_tc;
  wire key_ok;
  wire fields_ok;
  wire early;
  wire timeout;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle tick

  // Counting on a divided tick keeps all window figures in instruction cycles
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tc_cnt_r <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      if (tc_cnt_r == TC_DIV[3:0] - 4'h1) begin
        tc_cnt_r <= 4'h0;
        tick_r <= 1'b1;
      end else begin
        tc_cnt_r <= tc_cnt_r + 4'h1;
        tick_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock monitor

  swtcm_clkmon #(
    .LIMIT(CM_LIMIT),
    .CW(16)
  ) u_clkmon (
    .clk(CLOCK),
    .rst(RST),
    .enable(cm_en_r & wd_en),
    .mon_clk(CLOCK_INPUT_PIN),
    .err_r(cm_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign access = PSEL & PENABLE & PREADY;
  assign wr_svc = access & PWRITE & (PADDR == `SWTCM_ADDR_SVC);
  assign wr_opt = access & PWRITE & (PADDR == `SWTCM_ADDR_OPT);
  assign wr_stat = access & PWRITE & (PADDR == `SWTCM_ADDR_STAT);

  assign wd_en = ~opt_r[`SWTCM_OPT_WD_DIS_BIT];

  always @* begin
    addr_ok = 1'b1;
    rdata_mux = 32'h00000000;
    case (PADDR)
      `SWTCM_ADDR_SVC: begin
        // Key never leaves the block; reads show zeros there
        rdata_mux[7:0] = {sel_r, 5'h00, cm_en_r};
      end
      `SWTCM_ADDR_OPT: begin
        rdata_mux[7:0] = opt_r;
      end
      `SWTCM_ADDR_STAT: begin
        rdata_mux[`SWTCM_ST_FAULT] = FAULT_PIN_OE;
        rdata_mux[`SWTCM_ST_CMERR] = cm_err;
        rdata_mux[`SWTCM_ST_CONFIG] = config_r;
        rdata_mux[`SWTCM_ST_CLOCK:`SWTCM_ST_TIMEOUT] = cause_r;
      end
      `SWTCM_ADDR_CNT: begin
        rdata_mux[16:0] = win_cnt_r;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // One wait-free access phase: answer is staged during setup
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
      if (PSEL & ~PENABLE & ~PWRITE) begin
        PRDATA <= rdata_mux;
      end else begin
        PRDATA <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service checks

  assign upper_tc = `SWTCM_WIN_BASE_TC << sel_r;
  assign key_ok = PWDATA[`SWTCM_KEY_HI:`SWTCM_KEY_LO] == `SWTCM_KEY_VALUE;
  // Later services must repeat the key and both stored fields
  assign fields_ok = key_ok & (PWDATA[`SWTCM_SEL_HI:`SWTCM_SEL_LO] == sel_r)
                     & (PWDATA[`SWTCM_CM_BIT] == cm_en_r);
  // The very first service may land inside the lower bound
  assign early = config_r & (win_cnt_r < LOWER_TC[16:0]);
  assign timeout = tick_r & (win_cnt_r == upper_tc - 17'h00001);

  always @* begin
    configure_now = 1'b0;
    cause_set = 4'h0;
    if (state_r == ST_RUN && wd_en) begin
      if (wr_svc) begin
        if (!config_r) begin
          if (key_ok) begin
            configure_now = 1'b1;
          end else begin
            cause_set[2] = 1'b1;
          end
        end else if (!fields_ok) begin
          cause_set[2] = 1'b1;
        end else if (early) begin
          cause_set[1] = 1'b1;
        end
      end
      if (timeout) begin
        cause_set[0] = 1'b1;
      end
      if (cm_err) begin
        cause_set[3] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sel_r <= `SWTCM_SEL_RESET;
      cm_en_r <= `SWTCM_CM_RESET;
      config_r <= 1'b0;
      opt_r <= `SWTCM_OPT_RESET;
      cause_r <= 4'h0;
    end else begin
      if (configure_now) begin
        sel_r <= PWDATA[`SWTCM_SEL_HI:`SWTCM_SEL_LO];
        cm_en_r <= PWDATA[`SWTCM_CM_BIT];
        config_r <= 1'b1;
      end
      if (wr_opt) begin
        opt_r <= PWDATA[7:0];
      end
      // Write one to clear; a new cause in the same cycle wins
      if (wr_stat) begin
        cause_r <= (cause_r & ~PWDATA[`SWTCM_ST_CLOCK:`SWTCM_ST_TIMEOUT]) | cause_set;
      end else begin
        cause_r <= cause_r | cause_set;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault pin sequencer

  always @* begin
    state_nxt = state_r;
    win_cnt_nxt = win_cnt_r;
    hold_cnt_nxt = hold_cnt_r;
    case (state_r)
      ST_RUN: begin
        if (tick_r) begin
          win_cnt_nxt = win_cnt_r + 17'h00001;
        end
        if (configure_now || (wr_svc && config_r && fields_ok && !early)) begin
          win_cnt_nxt = 17'h00000;
        end
        if (!wd_en) begin
          win_cnt_nxt = 17'h00000;
        end else if (cause_set != 4'h0) begin
          state_nxt = ST_DRIVE;
          win_cnt_nxt = 17'h00000;
        end else if (!FAULT_PIN_IN) begin
          // Pin found low without our drive: treat as a trigger and time it out
          state_nxt = ST_HOLD;
          hold_cnt_nxt = 6'h00;
          win_cnt_nxt = 17'h00000;
        end
      end
      ST_DRIVE: begin
        if (!FAULT_PIN_IN) begin
          state_nxt = ST_HOLD;
          hold_cnt_nxt = 6'h00;
        end
      end
      ST_HOLD: begin
        // Tick granularity makes the stretch 16 to 17 cycles, inside 16-32
        if (cm_err) begin
          hold_cnt_nxt = 6'h00;
        end else if (tick_r) begin
          if (hold_cnt_r == HOLD_TC[5:0]) begin
            state_nxt = ST_REL;
          end else begin
            hold_cnt_nxt = hold_cnt_r + 6'h01;
          end
        end
      end
      ST_REL: begin
        if (FAULT_PIN_IN) begin
          state_nxt = ST_RUN;
          win_cnt_nxt = 17'h00000;
        end
      end
      default: begin
        state_nxt = ST_RUN;
        win_cnt_nxt = 17'h00000;
      end
    endcase
    // Disabling the pin function abandons any fault in progress
    if (!wd_en) begin
      state_nxt = ST_RUN;
    end
  end

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r <= ST_RUN;
      win_cnt_r <= 17'h00000;
      hold_cnt_r <= 6'h00;
      FAULT_PIN_OUT <= 1'b1;
      FAULT_PIN_OE <= 1'b0;
      FAULT_PIN_PULLUP <= 1'b0;
    end else begin
      state_r <= state_nxt;
      win_cnt_r <= win_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      // Open-drain style: only ever drive low
      FAULT_PIN_OE <= (state_nxt == ST_DRIVE) || (state_nxt == ST_HOLD);
      FAULT_PIN_OUT <= ~((state_nxt == ST_DRIVE) || (state_nxt == ST_HOLD));
      FAULT_PIN_PULLUP <= wd_en;
    end
  end

endmodule // swtcm_top

`default_nettype wire

/* File: test/swtcm_props.sv */
`timescale 1ns/10ps
`default_nettype none
module swtcm_props #(
  parameter integer TC_DIV = 10,
  parameter integer HOLD_TC = 16
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic FAULT_PIN_OUT,
  input wire logic FAULT_PIN_OE,
  input wire logic FAULT_PIN_PULLUP
);
  int oe_cnt;
  always @(posedge CLOCK or posedge RST) begin
    if (RST) oe_cnt <= 0;
    else oe_cnt <= FAULT_PIN_OE ? oe_cnt + 1 : 0;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside access");
  a_slverr_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_key_hidden: assert property (PREADY && !PWRITE && PADDR == 8'h00 |-> PRDATA[5:1] == 5'h00)
    else $error("key visible on read");
  a_svc_width: assert property (PREADY && !PWRITE && PADDR == 8'h00 |-> PRDATA[31:8] == 24'h0)
    else $error("service read too wide");
  a_pin_polarity: assert property (FAULT_PIN_OE == !FAULT_PIN_OUT)
    else $error("fault pin not active low");
  a_pin_enable: assert property (FAULT_PIN_OE |-> FAULT_PIN_PULLUP)
    else $error("fault driven while disabled");
  a_reset_exit: assert property ($fell(RST) |-> !FAULT_PIN_OE ##1 FAULT_PIN_PULLUP)
    else $error("bad state after reset");
  // Counted from the drive, which starts before the pin is seen low
  a_hold_min: assert property ($fell(FAULT_PIN_OE) && FAULT_PIN_PULLUP |-> $past(oe_cnt) >= HOLD_TC * TC_DIV)
    else $error("fault hold too short");
endmodule // swtcm_props
bind swtcm_top swtcm_props #(.TC_DIV(TC_DIV), .HOLD_TC(HOLD_TC)) swtcm_props_i (
  .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FAULT_PIN_OUT(FAULT_PIN_OUT),
  .FAULT_PIN_OE(FAULT_PIN_OE), .FAULT_PIN_PULLUP(FAULT_PIN_PULLUP));
`default_nettype wire

/* File: test/swtcm_reset_model.sv */
`timescale 1ns/10ps
`default_nettype none
module swtcm_reset_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic oe,
  input wire logic out_v,
  input wire logic pull_en,
  input wire logic hold_low,
  output wire logic pin
);
  logic flip_r;
  always @(posedge clk or posedge rst) begin
    if (rst) flip_r <= 1'b0;
    else flip_r <= ~flip_r;
  end
  // Without pull-up the line floats: held low during reset, then toggling every clock
  assign pin = ((oe && !out_v) || hold_low) ? 1'b0 : (pull_en ? 1'b1 : flip_r);
endmodule // swtcm_reset_model
`default_nettype wire

/* File: test/swtcm_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module swtcm_top_test;
  localparam int TCD = 2;
  localparam int HTC = 4;
  localparam int CML = 50;
  logic CLOCK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, CKPIN = 0, ck_run = 1, hold_low = 0, err;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, rd;
  logic [7:0] bad [3] = '{8'h59, 8'h18, 8'h1d};
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, PIN, POUT, POE, PPU;
  int error_cnt = 0, n_checks = 0, cyc = 0, n, i;
  swtcm_top #(.TC_DIV(TCD), .LOWER_TC(8), .HOLD_TC(HTC), .CM_LIMIT(CML)) swtcm_top_i (
    .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CLOCK_INPUT_PIN(CKPIN),
    .FAULT_PIN_IN(PIN), .FAULT_PIN_OUT(POUT), .FAULT_PIN_OE(POE), .FAULT_PIN_PULLUP(PPU));
  swtcm_reset_model swtcm_reset_model_i (.clk(CLOCK), .rst(RST), .oe(POE), .out_v(POUT),
    .pull_en(PPU), .hold_low(hold_low), .pin(PIN));
  initial begin
    forever #50 CLOCK = ~CLOCK;
  end
  ////////////////////////////////////////////////////////////
  always @(posedge CLOCK) begin
    if (ck_run) CKPIN <= ~CKPIN;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  task stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task wait_oe(input logic v, input int lim);
    n = 0;
    while (POE !== v && n < lim) begin
      @(posedge CLOCK);
      n++;
    end
  endtask
  task rel();
    wait_oe(1'b0, 400);
    chk(n >= HTC * TCD && n <= 2 * HTC * TCD + 4, "fault hold length");
    repeat (2) @(posedge CLOCK);
  endtask
  task fault(input int lim);
    wait_oe(1'b1, lim);
    chk(n < lim, "no fault raised");
    rel();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge CLOCK);
    RST <= 1'b0;
    // The line floats low until the pull-up comes on, so power-up is timed out first
    fault(10);
    apb(1'b0, 8'h00, 8'h00);
    chk(rd === 32'hc1 && err === 1'b0, "service reset value");
    apb(1'b0, 8'h10, 8'h00);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b1, 8'h00, 8'h19);
    apb(1'b0, 8'h00, 8'h00);
    chk(rd === 32'h01, "first write not loaded");
    $display("test reset done");
    apb(1'b1, 8'h00, 8'h19);
    fault(10);
    apb(1'b0, 8'h08, 8'h00);
    chk(rd === 32'h14, "early cause not flagged");
    apb(1'b1, 8'h08, 8'h10);
    $display("test early done");
    for (i = 0; i < 3; i++) begin
      repeat (24) @(posedge CLOCK);
      apb(1'b1, 8'h00, bad[i]);
      fault(10);
      apb(1'b0, 8'h00, 8'h00);
      chk(rd === 32'h01, "fields changed");
      apb(1'b0, 8'h08, 8'h00);
      chk(rd === 32'h24, "mismatch cause not flagged");
      apb(1'b1, 8'h08, 8'h20);
    end
    $display("test mismatch done");
    repeat (24) @(posedge CLOCK);
    apb(1'b1, 8'h00, 8'h19);
    wait_oe(1'b1, 30);
    chk(n == 30, "valid service faulted");
    // The window still runs during those 30 cycles
    wait_oe(1'b1, 17000);
    chk(n + 30 >= 8192 * TCD - 8 && n + 30 <= 8192 * TCD + 8, "upper bound");
    rel();
    $display("test timeout done");
    hold_low <= 1'b1;
    @(posedge CLOCK);
    hold_low <= 1'b0;
    fault(10);
    $display("test pin low done");
    ck_run <= 1'b0;
    wait_oe(1'b1, 200);
    chk(n >= CML - 4 && n <= CML + 10, "clock loss");
    repeat (100) @(posedge CLOCK);
    chk(POE === 1'b1, "error released while clock absent");
    ck_run <= 1'b1;
    rel();
    $display("test clock done");
    apb(1'b1, 8'h04, 8'h04);
    repeat (2) @(posedge CLOCK);
    chk(PPU === 1'b0 && POE === 1'b0, "pin still enabled");
    $display("test option done");
    stop_test();
  end
endmodule // swtcm_top_test
`default_nettype wire
